/* File: tte_pkg.sv */
// constants and types of the trigger and edge command interpreter
package tte_pkg;
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] OP_WIDTH = 8'h10;
  localparam logic [7:0] OP_OFFS = 8'h11;
  localparam logic [7:0] OP_EXTRA = 8'h12;
  localparam logic [7:0] OP_REJECT = 8'h13;
  localparam logic [7:0] OP_SUB_ON = 8'h14;
  localparam logic [7:0] OP_SUB_OFF = 8'h15;
  localparam logic [7:0] OP_TRIG_RD = 8'h16;
  localparam logic [7:0] OP_EDGE = 8'h22;
  localparam logic [7:0] OP_EDGE_RD = 8'h23;
  localparam logic [7:0] OP_LSB = 8'h24;
  localparam logic [7:0] OP_PAIR = 8'h25;
  localparam logic [7:0] OP_RES_RD = 8'h26;
  localparam logic [7:0] OP_DEAD = 8'h28;
  localparam logic [7:0] OP_DEAD_RD = 8'h29;
  localparam logic [11:0] WIDTH_RST = 12'h014;
  localparam logic [11:0] OFFS_RST = 12'hfd8;
  localparam logic [11:0] EXTRA_RST = 12'h008;
  localparam logic [11:0] REJECT_RST = 12'h004;
  localparam logic SUB_RST = 1'h0;
  localparam logic [1:0] EDGE_RST = 2'h2;
  localparam logic [1:0] EDGE_PAIR = 2'h0;
  localparam logic [1:0] LSB_RST = 2'h2;
  localparam logic [1:0] LSB_UNUSED = 2'h3;
  localparam logic [2:0] LEAD_RST = 3'h0;
  localparam logic [3:0] WRES_RST = 4'h0;
  localparam logic [3:0] WRES_MAX = 4'hd;
  localparam logic [1:0] DEAD_RST = 2'h0;
  localparam logic [2:0] TRIG_WORDS = 3'h5;
  localparam int LEAD_LO = 0;
  localparam int WRES_LO = 8;
  localparam int STAT_WR_BIT = 0;
  localparam int STAT_RD_BIT = 1;
  localparam int STAT_IDX_LO = 4;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_WR,
    ST_WAIT_RD
  } tte_state_type;
  typedef enum logic [3:0] {
    CMD_NONE, CMD_WIDTH, CMD_OFFS, CMD_EXTRA, CMD_REJECT,
    CMD_SUB_ON, CMD_SUB_OFF, CMD_TRIG_RD, CMD_EDGE, CMD_EDGE_RD,
    CMD_LSB, CMD_PAIR, CMD_RES_RD, CMD_DEAD, CMD_DEAD_RD
  } tte_cmd_type;
endpackage

/* File: tte_cmd_decode.sv */
// opcode decoder: command, parameter write and result word count
`timescale 1ns/1ps
`default_nettype none
module tte_cmd_decode (
  input wire logic [15:0] opcode,
  output var tte_pkg::tte_cmd_type cmd,
  output logic want_wr,
  output logic [2:0] rd_words
);
  always_comb begin
    cmd = tte_pkg::CMD_NONE;
    want_wr = 1'b0;
    rd_words = 3'h0;
    case (opcode[15:8])
      tte_pkg::OP_WIDTH: begin
        cmd = tte_pkg::CMD_WIDTH;
        want_wr = 1'b1;
      end
      tte_pkg::OP_OFFS: begin
        cmd = tte_pkg::CMD_OFFS;
        want_wr = 1'b1;
      end
      tte_pkg::OP_EXTRA: begin
        cmd = tte_pkg::CMD_EXTRA;
        want_wr = 1'b1;
      end
      tte_pkg::OP_REJECT: begin
        cmd = tte_pkg::CMD_REJECT;
        want_wr = 1'b1;
      end
      tte_pkg::OP_SUB_ON: cmd = tte_pkg::CMD_SUB_ON;
      tte_pkg::OP_SUB_OFF: cmd = tte_pkg::CMD_SUB_OFF;
      tte_pkg::OP_TRIG_RD: begin
        cmd = tte_pkg::CMD_TRIG_RD;
        rd_words = tte_pkg::TRIG_WORDS;
      end
      tte_pkg::OP_EDGE: begin
        cmd = tte_pkg::CMD_EDGE;
        want_wr = 1'b1;
      end
      tte_pkg::OP_EDGE_RD: begin
        cmd = tte_pkg::CMD_EDGE_RD;
        rd_words = 3'h1;
      end
      tte_pkg::OP_LSB: begin
        cmd = tte_pkg::CMD_LSB;
        want_wr = 1'b1;
      end
      tte_pkg::OP_PAIR: begin
        cmd = tte_pkg::CMD_PAIR;
        want_wr = 1'b1;
      end
      tte_pkg::OP_RES_RD: begin
        cmd = tte_pkg::CMD_RES_RD;
        rd_words = 3'h1;
      end
      tte_pkg::OP_DEAD: begin
        cmd = tte_pkg::CMD_DEAD;
        want_wr = 1'b1;
      end
      tte_pkg::OP_DEAD_RD: begin
        cmd = tte_pkg::CMD_DEAD_RD;
        rd_words = 3'h1;
      end
      default: cmd = tte_pkg::CMD_NONE;
    endcase
  end
endmodule
`default_nettype wire

/* File: tte_readback.sv */
// result word selection for the readback commands
`timescale 1ns/1ps
`default_nettype none
module tte_readback (
  input var tte_pkg::tte_cmd_type cmd,
  input wire logic [2:0] idx,
  input wire logic [11:0] width,
  input wire logic [11:0] offs,
  input wire logic [11:0] extra,
  input wire logic [11:0] reject,
  input wire logic sub_en,
  input wire logic [1:0] edge_mode,
  input wire logic [1:0] edge_lsb,
  input wire logic [2:0] lead_res,
  input wire logic [3:0] width_res,
  input wire logic [1:0] dead_time,
  output logic [15:0] word
);
  always_comb begin
    word = 16'h0000;
    case (cmd)
      tte_pkg::CMD_TRIG_RD: begin
        case (idx)
          3'h0: word = {4'h0, width};
          3'h1: word = {{4{offs[11]}}, offs};
          3'h2: word = {4'h0, extra};
          3'h3: word = {4'h0, reject};
          3'h4: word = {15'h0000, sub_en};
          default: word = 16'h0000;
        endcase
      end
      tte_pkg::CMD_EDGE_RD: word = {14'h0000, edge_mode};
      tte_pkg::CMD_RES_RD: begin
        if (edge_mode == tte_pkg::EDGE_PAIR) begin
          word[tte_pkg::LEAD_LO +: 3] = lead_res;
          word[tte_pkg::WRES_LO +: 4] = width_res;
        end else begin
          word = {14'h0000, edge_lsb};
        end
      end
      tte_pkg::CMD_DEAD_RD: word = {14'h0000, dead_time};
      default: word = 16'h0000;
    endcase
  end
endmodule
`default_nettype wire

/* File: tte_cmd_handler.sv */
// apb command port interpreter for trigger and edge settings
`timescale 1ns/1ps
`default_nettype none
module tte_cmd_handler (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [11:0] win_width,
  output logic [11:0] win_offset,
  output logic [11:0] extra_margin,
  output logic [11:0] reject_margin,
  output logic sub_enable,
  output logic [1:0] edge_mode,
  output logic [1:0] edge_lsb,
  output logic [2:0] lead_res,
  output logic [3:0] width_res,
  output logic [1:0] dead_time,
  output logic cmd_busy
);
  tte_pkg::tte_state_type state_ff;
  tte_pkg::tte_state_type nxt_state;
  tte_pkg::tte_cmd_type cmd_ff;
  tte_pkg::tte_cmd_type dec_cmd;
  logic dec_wr;
  logic [2:0] dec_rd;
  logic [2:0] idx_ff;
  logic [2:0] rd_cnt_ff;
  logic [11:0] width_ff;
  logic [11:0] offs_ff;
  logic [11:0] extra_ff;
  logic [11:0] reject_ff;
  logic sub_ff;
  logic [1:0] edge_ff;
  logic [1:0] lsb_ff;
  logic [2:0] lead_ff;
  logic [3:0] wres_ff;
  logic [1:0] dead_ff;
  logic [31:0] rdata_ff;
  logic err_ff;
  logic [15:0] rb_word;
  logic setup;
  logic access;
  logic hit_cmd;
  logic hit_stat;
  logic wr_go;
  logic rd_go;
  logic op_go;
  logic par_go;
  logic last_rd;
  logic [31:0] stat_word;
  logic nxt_err;

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign hit_cmd = (paddr == tte_pkg::ADDR_CMD);
  assign hit_stat = (paddr == tte_pkg::ADDR_STAT);
  // bus errors are refused transfers; they never move the interpreter
  assign wr_go = access & pwrite & hit_cmd & ~err_ff;
  assign rd_go = access & ~pwrite & hit_cmd & ~err_ff;
  assign op_go = wr_go & (state_ff == tte_pkg::ST_IDLE);
  assign par_go = wr_go & (state_ff == tte_pkg::ST_WAIT_WR);
  assign last_rd = (idx_ff == rd_cnt_ff - 3'h1);

  tte_cmd_decode u_decode (
    .opcode(pwdata[15:0]),
    .cmd(dec_cmd),
    .want_wr(dec_wr),
    .rd_words(dec_rd)
  );

  tte_readback u_readback (
    .cmd(cmd_ff),
    .idx(idx_ff),
    .width(width_ff),
    .offs(offs_ff),
    .extra(extra_ff),
    .reject(reject_ff),
    .sub_en(sub_ff),
    .edge_mode(edge_ff),
    .edge_lsb(lsb_ff),
    .lead_res(lead_ff),
    .width_res(wres_ff),
    .dead_time(dead_ff),
    .word(rb_word)
  );

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      tte_pkg::ST_IDLE: begin
        if (op_go && dec_wr) begin
          nxt_state = tte_pkg::ST_WAIT_WR;
        end else if (op_go && dec_rd != 3'h0) begin
          nxt_state = tte_pkg::ST_WAIT_RD;
        end
      end
      tte_pkg::ST_WAIT_WR: begin
        if (wr_go) begin
          nxt_state = tte_pkg::ST_IDLE;
        end
      end
      tte_pkg::ST_WAIT_RD: begin
        if (rd_go && last_rd) begin
          nxt_state = tte_pkg::ST_IDLE;
        end
      end
      default: nxt_state = tte_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= tte_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_ff <= tte_pkg::CMD_NONE;
      rd_cnt_ff <= 3'h0;
    end else if (op_go) begin
      cmd_ff <= dec_cmd;
      rd_cnt_ff <= dec_rd;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_ff <= 3'h0;
    end else if (op_go) begin
      idx_ff <= 3'h0;
    end else if (rd_go && state_ff == tte_pkg::ST_WAIT_RD) begin
      idx_ff <= last_rd ? 3'h0 : idx_ff + 3'h1;
    end
  end

  // values are cycle counts; the window start lands on a cycle edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      width_ff <= tte_pkg::WIDTH_RST;
      offs_ff <= tte_pkg::OFFS_RST;
      extra_ff <= tte_pkg::EXTRA_RST;
      reject_ff <= tte_pkg::REJECT_RST;
    end else if (par_go) begin
      case (cmd_ff)
        tte_pkg::CMD_WIDTH: width_ff <= pwdata[11:0];
        tte_pkg::CMD_OFFS: offs_ff <= pwdata[11:0];
        tte_pkg::CMD_EXTRA: extra_ff <= pwdata[11:0];
        tte_pkg::CMD_REJECT: reject_ff <= pwdata[11:0];
        default: width_ff <= width_ff;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub_ff <= tte_pkg::SUB_RST;
    end else if (op_go && dec_cmd == tte_pkg::CMD_SUB_ON) begin
      sub_ff <= 1'b1;
    end else if (op_go && dec_cmd == tte_pkg::CMD_SUB_OFF) begin
      sub_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_ff <= tte_pkg::EDGE_RST;
      lsb_ff <= tte_pkg::LSB_RST;
      dead_ff <= tte_pkg::DEAD_RST;
    end else if (par_go) begin
      case (cmd_ff)
        tte_pkg::CMD_EDGE: edge_ff <= pwdata[1:0];
        tte_pkg::CMD_LSB: begin
          // the unused code would leave the tdc undefined, so drop it
          if (pwdata[1:0] != tte_pkg::LSB_UNUSED) begin
            lsb_ff <= pwdata[1:0];
          end
        end
        tte_pkg::CMD_DEAD: dead_ff <= pwdata[1:0];
        default: edge_ff <= edge_ff;
      endcase
    end
  end

  // pair resolution only lands while pair mode is selected
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lead_ff <= tte_pkg::LEAD_RST;
      wres_ff <= tte_pkg::WRES_RST;
    end else if (par_go && cmd_ff == tte_pkg::CMD_PAIR &&
                 edge_ff == tte_pkg::EDGE_PAIR) begin
      lead_ff <= pwdata[tte_pkg::LEAD_LO +: 3];
      if (pwdata[tte_pkg::WRES_LO +: 4] <= tte_pkg::WRES_MAX) begin
        wres_ff <= pwdata[tte_pkg::WRES_LO +: 4];
      end
    end
  end

  always_comb begin
    stat_word = 32'h00000000;
    stat_word[tte_pkg::STAT_WR_BIT] = (state_ff == tte_pkg::ST_WAIT_WR);
    stat_word[tte_pkg::STAT_RD_BIT] = (state_ff == tte_pkg::ST_WAIT_RD);
    stat_word[tte_pkg::STAT_IDX_LO +: 3] = idx_ff;
  end

  // a read of the port with nothing to read, a write while results
  // wait, a write to status or an unmapped address is refused
  always_comb begin
    nxt_err = 1'b1;
    if (hit_cmd) begin
      if (pwrite) begin
        nxt_err = (state_ff == tte_pkg::ST_WAIT_RD);
      end else begin
        nxt_err = (state_ff != tte_pkg::ST_WAIT_RD);
      end
    end else if (hit_stat) begin
      nxt_err = pwrite;
    end
  end

  // read data is captured in the setup cycle so prdata is a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= 32'h00000000;
      err_ff <= 1'b0;
    end else if (setup) begin
      err_ff <= nxt_err;
      if (pwrite || nxt_err) begin
        rdata_ff <= 32'h00000000;
      end else if (hit_stat) begin
        rdata_ff <= stat_word;
      end else begin
        rdata_ff <= {16'h0000, rb_word};
      end
    end
  end

  assign prdata = rdata_ff;
  assign pready = 1'b1;
  assign pslverr = access & err_ff;
  assign win_width = width_ff;
  assign win_offset = offs_ff;
  assign extra_margin = extra_ff;
  assign reject_margin = reject_ff;
  assign sub_enable = sub_ff;
  assign edge_mode = edge_ff;
  assign edge_lsb = lsb_ff;
  assign lead_res = lead_ff;
  assign width_res = wres_ff;
  assign dead_time = dead_ff;
  assign cmd_busy = (state_ff != tte_pkg::ST_IDLE);

  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  width_load_a: assert property (
    par_go && cmd_ff == tte_pkg::CMD_WIDTH |=>
      win_width == $past(pwdata[11:0]))
    else $error("window width not applied");

  offs_sign_a: assert property (
    state_ff == tte_pkg::ST_WAIT_RD && cmd_ff == tte_pkg::CMD_TRIG_RD &&
      idx_ff == 3'h1 && setup && !pwrite && hit_cmd |=>
      prdata[15:12] == {4{win_offset[11]}})
    else $error("offset readback not sign extended");

  extra_mask_a: assert property (
    par_go && cmd_ff == tte_pkg::CMD_EXTRA |=>
      extra_margin == $past(pwdata[11:0]))
    else $error("extra margin not applied");

  sub_on_a: assert property (
    op_go && dec_cmd == tte_pkg::CMD_SUB_ON |=>
      sub_enable && state_ff == tte_pkg::ST_IDLE)
    else $error("subtraction not enabled");

  sub_off_a: assert property (
    op_go && dec_cmd == tte_pkg::CMD_SUB_OFF |=>
      !sub_enable && state_ff == tte_pkg::ST_IDLE)
    else $error("subtraction not disabled");

  trig_five_a: assert property (
    op_go && dec_cmd == tte_pkg::CMD_TRIG_RD |=>
      state_ff == tte_pkg::ST_WAIT_RD && rd_cnt_ff == 3'h5)
    else $error("trigger readback not five words");

  wr_wait_a: assert property (
    state_ff == tte_pkg::ST_WAIT_WR && !wr_go |=>
      state_ff == tte_pkg::ST_WAIT_WR)
    else $error("left write wait early");

  rd_wait_a: assert property (
    state_ff == tte_pkg::ST_WAIT_RD && !(rd_go && last_rd) |=>
      state_ff == tte_pkg::ST_WAIT_RD)
    else $error("left read wait early");

  edge_load_a: assert property (
    par_go && cmd_ff == tte_pkg::CMD_EDGE |=>
      edge_mode == $past(pwdata[1:0]) ##1 edge_mode == $past(edge_mode))
    else $error("edge mode not applied");

  lsb_valid_a: assert property (
    edge_lsb != tte_pkg::LSB_UNUSED)
    else $error("unused edge resolution code stored");

  wres_valid_a: assert property (
    width_res <= tte_pkg::WRES_MAX)
    else $error("invalid width resolution stored");

  dead_read_a: assert property (
    state_ff == tte_pkg::ST_WAIT_RD && cmd_ff == tte_pkg::CMD_DEAD_RD &&
      setup && !pwrite && hit_cmd |=> prdata[1:0] == dead_time)
    else $error("dead time readback wrong");

  edge_read_a: assert property (
    state_ff == tte_pkg::ST_WAIT_RD && cmd_ff == tte_pkg::CMD_EDGE_RD &&
      setup && !pwrite && hit_cmd |=> prdata[1:0] == edge_mode)
    else $error("edge mode readback wrong");

  // pair fields only show while pair mode is selected
  res_pair_a: assert property (
    state_ff == tte_pkg::ST_WAIT_RD && cmd_ff == tte_pkg::CMD_RES_RD &&
      edge_mode == tte_pkg::EDGE_PAIR && setup && !pwrite && hit_cmd |=>
      prdata[11:8] == width_res && prdata[2:0] == lead_res)
    else $error("pair resolution readback wrong");

  low_byte_a: assert property (
    op_go && pwdata[15:8] == tte_pkg::OP_WIDTH |=>
      state_ff == tte_pkg::ST_WAIT_WR && cmd_ff == tte_pkg::CMD_WIDTH)
    else $error("opcode low byte changed decode");

  trig_done_c: cover property (
    rd_go && cmd_ff == tte_pkg::CMD_TRIG_RD && last_rd);
  pair_set_c: cover property (
    par_go && cmd_ff == tte_pkg::CMD_PAIR && edge_mode == tte_pkg::EDGE_PAIR);
  res_single_c: cover property (
    rd_go && cmd_ff == tte_pkg::CMD_RES_RD && edge_mode != tte_pkg::EDGE_PAIR);
  refused_c: cover property (pslverr);
endmodule
`default_nettype wire

/* File: tte_host_model.sv */
// apb host model issuing command port transfers
`timescale 1ns/1ps
`default_nettype none
module tte_host_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // request held until pready seen; released bus shows inverted data
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
// self-checking bench of the trigger and edge command interpreter
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic sub_enable, cmd_busy, e_s, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [31:0] seed = 32'h0caee191;
  logic [11:0] win_width, win_offset, extra_margin, reject_margin;
  logic [11:0] e_w, e_o, e_x, e_r;
  logic [1:0] edge_mode, edge_lsb, dead_time, e_m, e_l, e_d;
  logic [2:0] lead_res, e_ld;
  logic [3:0] width_res, e_wr;
  int err_total, n_tests;

  tte_host_model i_tte_host_model (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  tte_cmd_handler i_tte_cmd_handler (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .win_width(win_width),
    .win_offset(win_offset), .extra_margin(extra_margin),
    .reject_margin(reject_margin), .sub_enable(sub_enable),
    .edge_mode(edge_mode), .edge_lsb(edge_lsb), .lead_res(lead_res),
    .width_res(width_res), .dead_time(dead_time), .cmd_busy(cmd_busy));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // pair fields only meaningful in pair mode, else edge code alone
  function automatic logic [15:0] exp_res();
    if (e_m == 2'h0) return {4'h0, e_wr, 5'h0, e_ld};
    return {14'h0, e_l};
  endfunction

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  task automatic chk_set(input logic [61:0] got, input logic [61:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_cfg();
    chk_set({win_width, win_offset, extra_margin, reject_margin, sub_enable,
      edge_mode, edge_lsb, lead_res, width_res, dead_time},
      {e_w, e_o, e_x, e_r, e_s, e_m, e_l, e_ld, e_wr, e_d});
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    i_tte_host_model.xfer(1'b1, a, {16'h0, d}, rdat, rerr);
  endtask
  task automatic rd(input logic [7:0] a);
    i_tte_host_model.xfer(1'b0, a, 32'h0, rdat, rerr);
  endtask

  task automatic op(input logic [7:0] c, input logic par,
                    input logic [15:0] p);
    logic [31:0] r;
    r = xs();
    wr(tte_pkg::ADDR_CMD, {c, r[7:0]});
    #1;
    chk_bit(cmd_busy, par);
    if (par) begin
      wr(tte_pkg::ADDR_CMD, p);
      #1;
      chk_bit(cmd_busy, 1'b0);
    end
    chk_cfg();
  endtask

  task automatic do_op(input int sel, input logic [15:0] p);
    logic [15:0] v;
    case (sel)
      0: begin
        v = (p % 16'd2088) + 16'd1;
        e_w = v[11:0];
        op(tte_pkg::OP_WIDTH, 1'b1, v);
      end
      1: begin
        v = (p % 16'd2089) - 16'd2048;
        e_o = v[11:0];
        op(tte_pkg::OP_OFFS, 1'b1, v);
      end
      2: begin
        v = {p[15:12], p[11:0] % 12'd51};
        e_x = v[11:0];
        op(tte_pkg::OP_EXTRA, 1'b1, v);
      end
      3: begin
        e_r = p[11:0];
        op(tte_pkg::OP_REJECT, 1'b1, p);
      end
      4: begin
        e_s = 1'b1;
        op(tte_pkg::OP_SUB_ON, 1'b0, 16'h0);
      end
      5: begin
        e_s = 1'b0;
        op(tte_pkg::OP_SUB_OFF, 1'b0, 16'h0);
      end
      6: begin
        e_m = p[1:0];
        op(tte_pkg::OP_EDGE, 1'b1, p);
      end
      7: begin
        if (p[1:0] != 2'h3) e_l = p[1:0];
        op(tte_pkg::OP_LSB, 1'b1, p);
      end
      8: begin
        e_m = 2'h0;
        op(tte_pkg::OP_EDGE, 1'b1, 16'h0);
        e_ld = p[2:0];
        if (p[11:8] <= 4'hd) e_wr = p[11:8];
        op(tte_pkg::OP_PAIR, 1'b1, p);
      end
      default: begin
        e_d = p[1:0];
        op(tte_pkg::OP_DEAD, 1'b1, p);
      end
    endcase
  endtask

  task automatic rd1(input logic [7:0] c, input logic [15:0] exp);
    wr(tte_pkg::ADDR_CMD, {c, 8'hc3});
    rd(tte_pkg::ADDR_CMD);
    chk_word(rdat, {16'h0, exp});
    #1;
    chk_bit(cmd_busy, 1'b0);
  endtask

  task automatic readall();
    logic [15:0] t [5];
    t = '{{4'h0, e_w}, {{4{e_o[11]}}, e_o}, {4'h0, e_x}, {4'h0, e_r},
      {15'h0, e_s}};
    wr(tte_pkg::ADDR_CMD, {tte_pkg::OP_TRIG_RD, 8'h5a});
    rd(tte_pkg::ADDR_STAT);
    chk_bit(rdat[1], 1'b1);
    for (int k = 0; k < 5; k++) begin
      // a write while results wait is refused and leaves the order intact
      if (k == 2) wr(tte_pkg::ADDR_CMD, 16'h1000);
      if (k == 2) chk_bit(rerr, 1'b1);
      rd(tte_pkg::ADDR_CMD);
      chk_word(rdat, {16'h0, t[k]});
      #1;
      chk_bit(cmd_busy, 1'(k < 4));
    end
    rd1(tte_pkg::OP_EDGE_RD, {14'h0, e_m});
    rd1(tte_pkg::OP_RES_RD, exp_res());
    rd1(tte_pkg::OP_DEAD_RD, {14'h0, e_d});
  endtask

  task automatic reset_dut();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    {e_w, e_o, e_x, e_r, e_s, e_m, e_l, e_ld, e_wr, e_d} = {12'h014,
      12'hfd8, 12'h008, 12'h004, 1'b0, 2'h2, 2'h2, 3'h0, 4'h0, 2'h0};
    #1;
    chk_cfg();
    chk_bit(cmd_busy, 1'b0);
    chk_word(prdata, 32'h0);
    chk_bit(pslverr, 1'b0);
    chk_bit(pready, 1'b1);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // generous bound: the whole sequence needs under 6000 cycles
  initial begin
    repeat (30000) @(posedge pclk);
    err_total++;
    summarize();
  end

  initial begin
    logic [31:0] r;
    presetn = 1'b0;
    err_total = 0;
    n_tests = 0;
    reset_dut();
    readall();
    for (int k = 0; k < 4; k++) begin
      do_op(6, 16'(k));
      do_op(7, 16'(k));
      do_op(9, 16'(k));
      readall();
    end
    for (int k = 0; k < 16; k++) begin
      do_op(8, {4'h0, 4'(k), 5'h0, 3'(k)});
      readall();
    end
    do_op(0, 16'd0);
    do_op(0, 16'd2087);
    do_op(1, 16'd0);
    do_op(1, 16'd2088);
    readall();
    for (int i = 0; i < 60; i++) begin
      r = xs();
      do_op(int'(r % 10), r[31:16]);
      readall();
    end
    // pair resolution outside pair mode must leave both fields alone
    do_op(6, 16'h0001);
    op(tte_pkg::OP_PAIR, 1'b1, 16'h0c05);
    readall();
    // refused accesses: idle result read, unmapped, read-only status
    rd(tte_pkg::ADDR_CMD);
    chk_bit(rerr, 1'b1);
    chk_word(rdat, 32'h0);
    rd(8'h08);
    chk_bit(rerr, 1'b1);
    wr(tte_pkg::ADDR_STAT, 16'h0001);
    chk_bit(rerr, 1'b1);
    wr(tte_pkg::ADDR_CMD, {tte_pkg::OP_WIDTH, 8'h00});
    rd(tte_pkg::ADDR_STAT);
    chk_bit(rdat[0], 1'b1);
    wr(tte_pkg::ADDR_CMD, 16'h0033);
    e_w = 12'h033;
    #1;
    chk_cfg();
    reset_dut();
    summarize();
  end
endmodule
`default_nettype wire
